// ---- dccd_consts.svh ----
// register indices, field positions and reset values of the channel clock dividers
// assumes an apb slave that multiplies each index by four to get the byte address
`ifndef DCCD_CONSTS_SVH
`define DCCD_CONSTS_SVH

// register indices; byte address is four times the index
`define DCCD_IDX_CH0_COUNTS 12'h190
`define DCCD_IDX_CH0_CONTROL 12'h191
`define DCCD_IDX_CH0_ROUTING 12'h192
`define DCCD_IDX_CH1_COUNTS 12'h196
`define DCCD_IDX_CH1_CONTROL 12'h197
`define DCCD_IDX_CH1_ROUTING 12'h198
`define DCCD_IDX_STATUS 12'h1A0

// count register fields
`define DCCD_LOW_MSB 7
`define DCCD_LOW_LSB 4
`define DCCD_HIGH_MSB 3
`define DCCD_HIGH_LSB 0

// control register fields
`define DCCD_BYPASS_BIT 7
`define DCCD_IGNORE_SYNC_BIT 6
`define DCCD_FORCE_LEVEL_BIT 5
`define DCCD_START_HIGH_BIT 4
`define DCCD_PHASE_MSB 3
`define DCCD_PHASE_LSB 0

// routing register fields
`define DCCD_DIRECT_ROUTE_BIT 1
`define DCCD_DUTY_OFF_BIT 0
`define DCCD_ROUTING_MASK 8'h03

// reset values
`define DCCD_RST_COUNTS 8'h00
`define DCCD_RST_CH0_CONTROL 8'h80
`define DCCD_RST_CH1_CONTROL 8'h00
`define DCCD_RST_ROUTING 8'h00

`endif

// ---- dccd_pkg.sv ----
// types shared by the channel clock divider design
// assumes nothing of its surroundings
package dccd_pkg;

    // divider sequencing states
    typedef enum logic [1:0] {
        DCCD_HOLD = 2'b00,
        DCCD_PHASE = 2'b01,
        DCCD_RUN = 2'b10
    } dccd_div_state_t;

    // clock source selection field of the chip clock source register
    typedef enum logic [1:0] {
        DCCD_SRC_EXT = 2'b00,
        DCCD_SRC_NONE = 2'b01,
        DCCD_SRC_OSC = 2'b10,
        DCCD_SRC_RSVD = 2'b11
    } dccd_src_t;

endpackage : dccd_pkg

// ---- dccd_divider.sv ----
// one channel divider: counts rising edges of the distribution clock
// assumes in_edge is a one-cycle pulse per input clock rising edge, on pclk
`timescale 1ns/1ns
module dccd_divider (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // settings
    input wire logic [3:0] low_count,
    input wire logic [3:0] high_count,
    input wire logic [3:0] phase_offset,
    input wire logic start_high,
    // control
    input wire logic in_edge,
    input wire logic hold,
    // result
    output logic out_level,
    output dccd_pkg::dccd_div_state_t state
);

    logic [3:0] count;
    logic [3:0] limit;

    assign limit = out_level ? high_count : low_count;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= dccd_pkg::DCCD_RUN;
        end else if (hold) begin
            state <= dccd_pkg::DCCD_HOLD;
        end else begin
            case (state)
                dccd_pkg::DCCD_HOLD: begin
                    state <= (phase_offset == 4'h0) ? dccd_pkg::DCCD_RUN : dccd_pkg::DCCD_PHASE;
                end
                dccd_pkg::DCCD_PHASE: begin
                    if (in_edge && count == phase_offset - 4'h1) begin
                        state <= dccd_pkg::DCCD_RUN;
                    end
                end
                default: begin
                    state <= dccd_pkg::DCCD_RUN;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= 4'h0;
        end else if (hold || state == dccd_pkg::DCCD_HOLD) begin
            count <= 4'h0;
        end else if (in_edge) begin
            if (state == dccd_pkg::DCCD_PHASE) begin
                count <= (count == phase_offset - 4'h1) ? 4'h0 : count + 4'h1;
            end else if (count == limit) begin
                count <= 4'h0;
            end else begin
                count <= count + 4'h1;
            end
        end
    end

    // each level lasts limit + 1 input edges, so the period is low + high + 2
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_level <= 1'b0;
        end else if (hold || state != dccd_pkg::DCCD_RUN) begin
            out_level <= start_high;
        end else if (in_edge && count == limit) begin
            out_level <= ~out_level;
        end
    end

endmodule : dccd_divider

// ---- dccd_top.sv ----
// two channel clock dividers with their apb register file and output routing
// assumes all clock-like inputs are slow levels sampled on pclk, 100 MHz
`timescale 1ns/1ns
`include "dccd_consts.svh"

// What this block does
// - output stays low for low-count field plus one input clock cycles
// - output stays high for high-count field plus one input clock cycles
// - count field zero gives one cycle; both count fields reset to zero
// - bypass bit powers divider down and passes input clock straight through
// - channel zero resets bypassed; channel one resets dividing
// - ignore-sync bit clear obeys chip sync, set disregards it; resets clear
// - force-level bit gives static high or low while chip sync is asserted; needs ignore-sync set too
// - start-level bit picks the output level when the divider starts
// - four-bit phase offset per channel sets coarse phase; resets to zero
// - direct-route bit feeds pair from oscillator (10b) or external clock (00b)
// - source select 01b makes direct-route inert; clear bit leaves pair to bypass, forced level or divider
// - duty-correction disable bit: zero keeps correction on, one turns it off
// - second channel keeps start-level at bit 4, phase at bits 3 to 0
module dccd_top (
    // apb clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [13:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // clock sources and chip controls
    input wire logic dist_clk,
    input wire logic internal_oscillator,
    input wire logic ext_clk,
    input wire logic [1:0] source_select,
    input wire logic chip_sync,
    // first output pair
    output logic first_pair_output_a,
    output logic first_pair_output_b,
    output logic first_duty_correction_on,
    output logic first_divider_powered_down,
    // second output pair
    output logic second_pair_output_a,
    output logic second_pair_output_b,
    output logic second_duty_correction_on,
    output logic second_divider_powered_down
);

    // registers
    logic [7:0] channel0_divide_counts;
    logic [7:0] channel0_divider_control;
    logic [7:0] channel0_routing_duty;
    logic [7:0] channel1_divide_counts;
    logic [7:0] channel1_divider_control;
    logic [7:0] channel1_routing_duty;

    // apb decode
    logic [11:0] reg_index;
    logic addr_aligned;
    logic write_access;
    logic setup_phase;
    logic mapped;
    logic [7:0] read_value;

    // input clock edge detection
    logic dist_clk_prev;
    logic dist_edge;

    // per channel datapath
    logic [1:0] div_level;
    dccd_pkg::dccd_div_state_t div_state [2];
    logic [1:0] hold;
    logic [1:0] bypass;
    logic [1:0] ignore_sync;
    logic [1:0] force_level;
    logic [1:0] direct_route;
    logic [1:0] next_out;
    logic [1:0] pair_out;

    assign reg_index = paddr[13:2];
    assign addr_aligned = (paddr[1:0] == 2'b00);
    assign setup_phase = psel && !penable;
    assign write_access = psel && penable && pwrite && mapped && addr_aligned;

    // address decode
    always_comb begin
        mapped = 1'b1;
        read_value = 8'h00;
        if (reg_index == `DCCD_IDX_CH0_COUNTS) begin
            read_value = channel0_divide_counts;
        end else if (reg_index == `DCCD_IDX_CH0_CONTROL) begin
            read_value = channel0_divider_control;
        end else if (reg_index == `DCCD_IDX_CH0_ROUTING) begin
            read_value = channel0_routing_duty;
        end else if (reg_index == `DCCD_IDX_CH1_COUNTS) begin
            read_value = channel1_divide_counts;
        end else if (reg_index == `DCCD_IDX_CH1_CONTROL) begin
            read_value = channel1_divider_control;
        end else if (reg_index == `DCCD_IDX_CH1_ROUTING) begin
            read_value = channel1_routing_duty;
        end else if (reg_index == `DCCD_IDX_STATUS) begin
            read_value = {div_state[1], div_state[0], hold, pair_out};
        end else begin
            mapped = 1'b0;
        end
    end

    // zero wait states; read data is captured in the setup cycle
    assign pready = 1'b1;
    assign pslverr = psel && penable && !(mapped && addr_aligned);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (setup_phase && !pwrite) begin
            prdata <= (mapped && addr_aligned) ? {24'h00_0000, read_value} : 32'h0000_0000;
        end
    end

    // count registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            channel0_divide_counts <= `DCCD_RST_COUNTS;
            channel1_divide_counts <= `DCCD_RST_COUNTS;
        end else if (write_access) begin
            if (reg_index == `DCCD_IDX_CH0_COUNTS) begin
                channel0_divide_counts <= pwdata[7:0];
            end else if (reg_index == `DCCD_IDX_CH1_COUNTS) begin
                channel1_divide_counts <= pwdata[7:0];
            end
        end
    end

    // control registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            channel0_divider_control <= `DCCD_RST_CH0_CONTROL;
            channel1_divider_control <= `DCCD_RST_CH1_CONTROL;
        end else if (write_access) begin
            if (reg_index == `DCCD_IDX_CH0_CONTROL) begin
                channel0_divider_control <= pwdata[7:0];
            end else if (reg_index == `DCCD_IDX_CH1_CONTROL) begin
                channel1_divider_control <= pwdata[7:0];
            end
        end
    end

    // routing and duty registers; only the two low bits exist
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            channel0_routing_duty <= `DCCD_RST_ROUTING;
            channel1_routing_duty <= `DCCD_RST_ROUTING;
        end else if (write_access) begin
            if (reg_index == `DCCD_IDX_CH0_ROUTING) begin
                channel0_routing_duty <= pwdata[7:0] & `DCCD_ROUTING_MASK;
            end else if (reg_index == `DCCD_IDX_CH1_ROUTING) begin
                channel1_routing_duty <= pwdata[7:0] & `DCCD_ROUTING_MASK;
            end
        end
    end

    // rising edges of the distribution clock mark input clock cycles
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dist_clk_prev <= 1'b0;
        end else begin
            dist_clk_prev <= dist_clk;
        end
    end

    assign dist_edge = dist_clk && !dist_clk_prev;

    // field extraction
    assign bypass[0] = channel0_divider_control[`DCCD_BYPASS_BIT];
    assign bypass[1] = channel1_divider_control[`DCCD_BYPASS_BIT];
    assign ignore_sync[0] = channel0_divider_control[`DCCD_IGNORE_SYNC_BIT];
    assign ignore_sync[1] = channel1_divider_control[`DCCD_IGNORE_SYNC_BIT];
    assign force_level[0] = channel0_divider_control[`DCCD_FORCE_LEVEL_BIT];
    assign force_level[1] = channel1_divider_control[`DCCD_FORCE_LEVEL_BIT];
    assign direct_route[0] = channel0_routing_duty[`DCCD_DIRECT_ROUTE_BIT];
    assign direct_route[1] = channel1_routing_duty[`DCCD_DIRECT_ROUTE_BIT];

    // divider held while sync is obeyed and asserted, or while powered down
    assign hold[0] = (chip_sync && !ignore_sync[0]) || bypass[0];
    assign hold[1] = (chip_sync && !ignore_sync[1]) || bypass[1];

    dccd_divider u_div0 (
        .pclk(pclk),
        .presetn(presetn),
        .low_count(channel0_divide_counts[`DCCD_LOW_MSB:`DCCD_LOW_LSB]),
        .high_count(channel0_divide_counts[`DCCD_HIGH_MSB:`DCCD_HIGH_LSB]),
        .phase_offset(channel0_divider_control[`DCCD_PHASE_MSB:`DCCD_PHASE_LSB]),
        .start_high(channel0_divider_control[`DCCD_START_HIGH_BIT]),
        .in_edge(dist_edge),
        .hold(hold[0]),
        .out_level(div_level[0]),
        .state(div_state[0])
    );

    dccd_divider u_div1 (
        .pclk(pclk),
        .presetn(presetn),
        .low_count(channel1_divide_counts[`DCCD_LOW_MSB:`DCCD_LOW_LSB]),
        .high_count(channel1_divide_counts[`DCCD_HIGH_MSB:`DCCD_HIGH_LSB]),
        .phase_offset(channel1_divider_control[`DCCD_PHASE_MSB:`DCCD_PHASE_LSB]),
        .start_high(channel1_divider_control[`DCCD_START_HIGH_BIT]),
        .in_edge(dist_edge),
        .hold(hold[1]),
        .out_level(div_level[1]),
        .state(div_state[1])
    );

    // output selection per channel, priority: direct route, bypass, forced level, divider
    always_comb begin
        for (int ch = 0; ch < 2; ch++) begin
            next_out[ch] = div_level[ch];
            if (direct_route[ch] && source_select == dccd_pkg::DCCD_SRC_OSC) begin
                next_out[ch] = internal_oscillator;
            end else if (direct_route[ch] && source_select == dccd_pkg::DCCD_SRC_EXT) begin
                next_out[ch] = ext_clk;
            end else if (bypass[ch]) begin
                next_out[ch] = dist_clk;
            end else if (ignore_sync[ch] && chip_sync) begin
                next_out[ch] = force_level[ch];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pair_out <= 2'b00;
        end else begin
            pair_out <= next_out;
        end
    end

    assign first_pair_output_a = pair_out[0];
    assign first_pair_output_b = pair_out[0];
    assign second_pair_output_a = pair_out[1];
    assign second_pair_output_b = pair_out[1];

    // duty correction and power state flags
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            first_duty_correction_on <= 1'b1;
            second_duty_correction_on <= 1'b1;
            first_divider_powered_down <= 1'b1;
            second_divider_powered_down <= 1'b0;
        end else begin
            first_duty_correction_on <= !channel0_routing_duty[`DCCD_DUTY_OFF_BIT];
            second_duty_correction_on <= !channel1_routing_duty[`DCCD_DUTY_OFF_BIT];
            first_divider_powered_down <= bypass[0];
            second_divider_powered_down <= bypass[1];
        end
    end

endmodule : dccd_top

// ---- dccd_monitor.sv ----
// checker for the channel divider block, watching only the top ports
// assumes it is bound to dccd_top and that pclk runs faster than dist_clk
`timescale 1ns/1ns
module dccd_monitor (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // sources
    input wire logic dist_clk,
    input wire logic [1:0] source_select,
    input wire logic chip_sync,
    // outputs
    input wire logic first_pair_output_a,
    input wire logic second_pair_output_a,
    input wire logic second_pair_output_b,
    input wire logic first_duty_correction_on,
    input wire logic second_duty_correction_on,
    input wire logic first_divider_powered_down,
    input wire logic second_divider_powered_down
);
    logic dist_prev;
    logic [2:0] since_rise;
    logic [2:0] quiet;

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // cycles since the last input clock rise, and since sync or bypass was seen
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dist_prev <= 1'b0;
            since_rise <= 3'h7;
            quiet <= 3'h0;
        end else begin
            dist_prev <= dist_clk;
            since_rise <= (dist_clk && !dist_prev) ? 3'h0 : since_rise + {2'h0, since_rise != 3'h7};
            quiet <= (chip_sync || second_divider_powered_down) ? 3'h0 : quiet + {2'h0, quiet != 3'h7};
        end
    end

    sequence s_sync_held;
        (chip_sync && !second_divider_powered_down) [*4];
    endsequence
    sequence s_free_toggle;
        $changed(second_pair_output_a) && quiet > 3'h4;
    endsequence

    property p_ready;
        pready;
    endproperty
    property p_err_phase;
        pslverr |-> psel && penable;
    endproperty
    property p_upper_zero;
        prdata[31:8] == 24'h000000;
    endproperty
    property p_reset_state;
        $rose(presetn) |-> first_divider_powered_down && !second_divider_powered_down;
    endproperty
    property p_duty_reset;
        $rose(presetn) |-> first_duty_correction_on && second_duty_correction_on;
    endproperty
    property p_bypass_pass;
        $past(presetn) && $past(first_divider_powered_down) && first_divider_powered_down
            && $past(source_select[0]) |-> first_pair_output_a == $past(dist_clk);
    endproperty
    property p_sync_static;
        s_sync_held |-> $stable(second_pair_output_a);
    endproperty
    property p_edge_cause;
        s_free_toggle |-> since_rise < 3'h4;
    endproperty
    property p_pair_same;
        second_pair_output_a == second_pair_output_b;
    endproperty

    a_ready: assert property (p_ready)
        else $error("pready low");
    a_err_phase: assert property (p_err_phase)
        else $error("pslverr outside access phase");
    a_upper_zero: assert property (p_upper_zero)
        else $error("read data upper bits not zero");
    a_reset_state: assert property (p_reset_state)
        else $error("divider bypass state wrong after reset");
    a_duty_reset: assert property (p_duty_reset)
        else $error("duty correction off after reset");
    a_bypass_pass: assert property (p_bypass_pass)
        else $error("bypassed output does not follow input clock");
    a_sync_static: assert property (p_sync_static)
        else $error("output moves while sync held");
    a_edge_cause: assert property (p_edge_cause)
        else $error("divider output changed without input clock edge");
    a_pair_same: assert property (p_pair_same)
        else $error("second pair outputs differ");
endmodule : dccd_monitor

bind dccd_top dccd_monitor i_mon (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .dist_clk(dist_clk), .source_select(source_select), .chip_sync(chip_sync),
    .first_pair_output_a(first_pair_output_a), .second_pair_output_a(second_pair_output_a),
    .second_pair_output_b(second_pair_output_b),
    .first_duty_correction_on(first_duty_correction_on),
    .second_duty_correction_on(second_duty_correction_on),
    .first_divider_powered_down(first_divider_powered_down),
    .second_divider_powered_down(second_divider_powered_down));

// ---- differential_channel_clock_divider_tb.sv ----
// self-checking bench for the channel divider block over apb
// assumes dist_clk period of 8 pclk cycles made here, all inputs driven here
`timescale 1ns/1ns
module differential_channel_clock_divider_tb;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [13:0] paddr;
    logic [31:0] pwdata, prdata;
    logic dist_clk = 1'b0, internal_oscillator = 1'b0, ext_clk = 1'b0, chip_sync;
    logic [1:0] source_select;
    logic fp_a, fp_b, dc0, pd0, sp_a, sp_b, dc1, pd1;
    logic [3:0] dcnt = 4'h0;
    int num_errors, n_tests, ta, tb;

    dccd_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .dist_clk(dist_clk), .internal_oscillator(internal_oscillator),
        .ext_clk(ext_clk), .source_select(source_select), .chip_sync(chip_sync),
        .first_pair_output_a(fp_a), .first_pair_output_b(fp_b),
        .first_duty_correction_on(dc0), .first_divider_powered_down(pd0),
        .second_pair_output_a(sp_a), .second_pair_output_b(sp_b),
        .second_duty_correction_on(dc1), .second_divider_powered_down(pd1));

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    // three slow clock sources, all derived from the one dcnt counter
    always @(posedge pclk) begin
        dcnt <= dcnt + 4'h1;
        dist_clk <= dcnt[2];
        ext_clk <= dcnt[1];
        internal_oscillator <= dcnt[0] ^ dcnt[3];
    end

    task close_out;
        $display("mismatches %0d comparisons %0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : close_out
    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task apb(input logic w, input logic [13:0] a, input logic [31:0] d,
             output logic [31:0] r, output logic e);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            chk("pready", 32'h1, 32'h0);
            close_out();
        end
    endtask : apb
    task rd(input logic [13:0] a, input logic [7:0] exp, input logic eerr);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        chk("read data", {24'h0, exp}, r);
        chk("slave error", {31'h0, eerr}, {31'h0, e});
    endtask : rd
    task wr(input logic [13:0] a, input logic [7:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, {24'h0, d}, r, e);
        chk("write error", 32'h0, {31'h0, e});
    endtask : wr
    task wait_for(input bit ch, input logic lvl, output int n);
        n = 0;
        #1;
        while ((ch ? sp_a : fp_a) !== lvl && n < 400) begin
            @(posedge pclk);
            #1;
            n++;
        end
        if (n >= 400) begin
            chk("output level", {31'h0, lvl}, {31'h0, ~lvl});
            close_out();
        end
    endtask : wait_for
    task measure(input bit ch, input logic [7:0] c);
        int n, nh, nl;
        wait_for(ch, 1'b0, n);
        wait_for(ch, 1'b1, n);
        wait_for(ch, 1'b0, nh);
        wait_for(ch, 1'b1, nl);
        chk("high cycles", (c[3:0] + 1) * 8, nh);
        chk("low cycles", (c[7:4] + 1) * 8, nl);
    endtask : measure
    function logic pick(input int s);
        return s == 0 ? ext_clk : (s == 1 ? internal_oscillator : dist_clk);
    endfunction : pick
    task follow(input logic [1:0] sel, input int s);
        logic prev;
        @(posedge pclk);
        source_select <= sel;
        repeat (3) @(posedge pclk);
        #1;
        prev = pick(s);
        repeat (12) begin
            @(posedge pclk);
            #1;
            chk("first pair output", {31'h0, prev}, {31'h0, fp_a});
            chk("first pair output b", {31'h0, prev}, {31'h0, fp_b});
            prev = pick(s);
        end
    endtask : follow
    task sync_hold(input logic [7:0] ctl, output int t);
        logic exp;
        int k;
        exp = ctl[6] ? ctl[5] : ctl[4];
        wr(14'h065C, ctl);
        chip_sync <= 1'b1;
        repeat (6) @(posedge pclk);
        repeat (20) begin
            @(posedge pclk);
            #1;
            chk("held output", {31'h0, exp}, {31'h0, sp_a});
        end
        k = 0;
        while (dcnt !== 4'h0 && k < 16) begin
            @(posedge pclk);
            #1;
            k++;
        end
        if (dcnt !== 4'h0) begin
            chk("sync alignment", 32'h0, {28'h0, dcnt});
            close_out();
        end
        @(posedge pclk);
        chip_sync <= 1'b0;
        wait_for(1'b1, ~exp, t);
    endtask : sync_hold

    task t_reset_values;
        rd(14'h0640, 8'h00, 1'b0);
        rd(14'h0644, 8'h80, 1'b0);
        rd(14'h0648, 8'h00, 1'b0);
        rd(14'h0658, 8'h00, 1'b0);
        rd(14'h065C, 8'h00, 1'b0);
        rd(14'h0660, 8'h00, 1'b0);
        rd(14'h0700, 8'h00, 1'b1);
        chk("first powered down", 32'h1, {31'h0, pd0});
        chk("second powered down", 32'h0, {31'h0, pd1});
        chk("duty correction", 32'h3, {30'h0, dc1, dc0});
    endtask : t_reset_values
    task t_divide;
        logic [7:0] tbl [4];
        tbl = '{8'h00, 8'h31, 8'hF0, 8'h0F};
        foreach (tbl[i]) begin
            wr(14'h0658, tbl[i]);
            rd(14'h0658, tbl[i], 1'b0);
            measure(1'b1, tbl[i]);
        end
    endtask : t_divide
    task t_bypass;
        follow(2'b01, 2);
        wr(14'h0644, 8'h00);
        repeat (2) @(posedge pclk);
        chk("first powered down", 32'h0, {31'h0, pd0});
        measure(1'b0, 8'h00);
    endtask : t_bypass
    task t_route;
        wr(14'h0644, 8'h80);
        wr(14'h0648, 8'h02);
        follow(2'b00, 0);
        follow(2'b10, 1);
        follow(2'b01, 2);
        wr(14'h0648, 8'h01);
        follow(2'b00, 2);
        chk("first duty correction", 32'h0, {31'h0, dc0});
        source_select <= 2'b01;
    endtask : t_route
    task t_sync;
        wr(14'h0658, 8'h00);
        sync_hold(8'h00, ta);
        sync_hold(8'h60, ta);
        sync_hold(8'h40, ta);
        sync_hold(8'h10, ta);
        sync_hold(8'h13, tb);
        chk("phase delay", 32'd24, tb - ta);
    endtask : t_sync

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 14'h0000;
        pwdata = 32'h0;
        chip_sync = 1'b0;
        source_select = 2'b01;
        num_errors = 0;
        n_tests = 0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        t_reset_values();
        t_divide();
        t_bypass();
        t_route();
        t_sync();
        close_out();
    end
endmodule : differential_channel_clock_divider_tb
